// ### include/amx_pkg.sv
// package for the multiplexed acquisition serial sequencer
// assumes one 100 MHz core clock shared by both ends of the link
// Contract
// - results are 16-bit two's complement counts
// - downstream channel frames open on the upstream sync
// - each direction: bit clock, data, load
// - channel shifts into byte register, drives mux
// - host output channel carries only channel selections
// - one bit clock times converter and link
// - device drives clock, host returns it
// - conversion pulse divided, at least 72 ticks
// - slower rates allowed, decimation preferred
// - sync follows each conversion command; here only when the fifo holds a result
// - sync is input load, result then sent
// - host ties output load to input load
// - result lags its channel by three pulses
// - first pulse: channel shifts in, mux settles
// - second pulse: selected channel is sampled
// - third pulse: converted value is transmitted
// - 12-bit up counter, pulse on wrap
// - low three bits tier one, high tier two
package amx_pkg;
   localparam int unsigned CORE_HZ        = 100_000_000;
   localparam int unsigned BIT_HZ         = 10_000_000;
   // half period of the bit clock in core cycles
   localparam int unsigned BIT_HALF       = CORE_HZ / BIT_HZ / 2;
   localparam int unsigned RESULT_W       = 16;
   localparam int unsigned CHAN_W         = 6;
   localparam int unsigned CHREG_W        = 8;
   localparam int unsigned TIER_W         = 3;
   localparam int unsigned DIV_W          = 12;
   localparam int unsigned MIN_TICKS      = 72;
   // start count so that the counter wraps every 72 ticks
   localparam logic [11:0] DIV_START_RST  = 12'hFB8;
   localparam logic [15:0] FULL_POS       = 16'h7FFF;
   localparam logic [15:0] FULL_NEG       = 16'h8000;
   localparam int unsigned FIFO_DEPTH     = 4;
   localparam int unsigned LAG_PULSES     = 3;
   typedef logic [RESULT_W-1:0] amx_result_t;
   typedef logic [CHAN_W-1:0]   amx_chan_t;
endpackage

// ### include/amx_link_if.sv
// three-wire serial link, one group each direction
// assumes both ends sit in the same core clock domain
interface amx_link_if;
   logic bitClk;      // device makes it
   logic retClk;      // host returns it
   logic upData;      // result toward host
   logic upLoad;      // input load strobe (sync)
   logic downData;    // channel toward device
   logic downLoad;    // output load strobe
   modport device (output bitClk, output upData, output upLoad,
                   input retClk, input downData, input downLoad);
   modport host   (input bitClk, input upData, input upLoad,
                   output retClk, output downData, output downLoad);
endinterface

// ### design/amx_fifo.sv
// small synchronous FIFO with valid/ready on both sides
// assumes a single clock and async active-low reset
module amx_fifo #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 4
) (
   input  wire logic             core_clk,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic [WIDTH-1:0]      outData,
   output logic                  outValid,
   input  wire logic             outReady
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr_q;
   logic [AW-1:0]    rdPtr_q;
   logic [AW:0]      count_q;
   logic             push;
   logic             pop;
   logic [AW:0]      countNext;
   logic             inReady_q;

   // ready is registered so that the refusal comes straight from a flop
   assign countNext = count_q + (AW+1)'(push) - (AW+1)'(pop);
   assign inReady  = inReady_q;
   assign outValid = (count_q != '0);
   assign outData  = mem[rdPtr_q];
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wrPtr_q] <= inData;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
         inReady_q <= 1'b1;
      end else begin
         if (push) begin
            wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
         end
         if (pop) begin
            rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
         end
         count_q   <= countNext;
         inReady_q <= (countNext != (AW+1)'(DEPTH));
      end
   end
endmodule

// ### design/amx_device.sv
// acquisition board end: bit clock, rate divider, result sender,
// channel receiver and multiplexer address
// assumes the host returns the bit clock and ties its load strobes
module amx_device
   import amx_pkg::*;
#(
   parameter logic [11:0] DIV_START = amx_pkg::DIV_START_RST,
   parameter int unsigned DEPTH     = amx_pkg::FIFO_DEPTH
) (
   input  wire logic          core_clk,
   input  wire logic          resetn,
   amx_link_if.device         link,
   input  wire amx_pkg::amx_result_t convData,
   input  wire logic          convValid,
   output logic               convReady,
   output logic               convPulse,
   output logic [2:0]         muxLow,
   output logic [2:0]         muxHigh
);
   import amx_pkg::*;

   // ************************************************************
   // bit clock generation
   // ************************************************************
   logic [3:0] halfCnt_q;
   logic       bitClk_q;
   logic       riseTick;
   logic       fallTick;

   assign riseTick = (halfCnt_q == 4'(BIT_HALF-1)) && !bitClk_q;
   assign fallTick = (halfCnt_q == 4'(BIT_HALF-1)) && bitClk_q;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         halfCnt_q <= '0;
         bitClk_q  <= 1'b0;
      end else if (halfCnt_q == 4'(BIT_HALF-1)) begin
         halfCnt_q <= '0;
         bitClk_q  <= !bitClk_q;
      end else begin
         halfCnt_q <= halfCnt_q + 4'h1;
      end
   end

   // ************************************************************
   // conversion rate divider
   // ************************************************************
   logic [DIV_W-1:0] divCnt_q;
   logic             wrap;
   logic             convPulse_q;

   assign wrap = riseTick && (divCnt_q == 12'hFFF);

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         divCnt_q    <= DIV_START;
         convPulse_q <= 1'b0;
      end else begin
         convPulse_q <= wrap;
         if (wrap) begin
            divCnt_q <= DIV_START;
         end else if (riseTick) begin
            divCnt_q <= divCnt_q + 12'h001;
         end
      end
   end
   assign convPulse = convPulse_q;

   // ************************************************************
   // result buffering and upstream sender
   // ************************************************************
   amx_result_t fifoData;
   logic        fifoValid;
   logic        fifoPop;

   // converter results wait here; the sender drains one per frame
   amx_fifo #(.WIDTH(RESULT_W), .DEPTH(DEPTH)) i_amx_fifo (
      .core_clk (core_clk),
      .resetn   (resetn),
      .inData   (convData),
      .inValid  (convValid),
      .inReady  (convReady),
      .outData  (fifoData),
      .outValid (fifoValid),
      .outReady (fifoPop)
   );

   typedef enum logic [1:0] {UP_IDLE, UP_SYNC, UP_SHIFT} amx_up_t;
   amx_up_t     upState_q;
   amx_result_t upShift_q;
   logic [4:0]  upBits_q;
   logic        upLoad_q;
   logic        upData_q;
   logic        armed_q;

   assign fifoPop = (upState_q == UP_IDLE) && armed_q && fifoValid
                    && fallTick;

   // a pulse arms one frame; frames change on falling bit clock edges
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         armed_q <= 1'b0;
      end else if (convPulse_q) begin
         armed_q <= 1'b1;
      end else if (fifoPop) begin
         armed_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         upState_q <= UP_IDLE;
         upShift_q <= '0;
         upBits_q  <= '0;
         upLoad_q  <= 1'b0;
         upData_q  <= 1'b0;
      end else if (fallTick) begin
         unique case (upState_q)
            UP_IDLE: begin
               if (armed_q && fifoValid) begin
                  upShift_q <= fifoData;
                  upLoad_q  <= 1'b1;
                  upState_q <= UP_SYNC;
               end
            end
            UP_SYNC: begin
               upLoad_q  <= 1'b0;
               upData_q  <= upShift_q[RESULT_W-1];
               upShift_q <= {upShift_q[RESULT_W-2:0], 1'b0};
               upBits_q  <= 5'h01;
               upState_q <= UP_SHIFT;
            end
            UP_SHIFT: begin
               if (upBits_q == 5'(RESULT_W)) begin
                  upData_q  <= 1'b0;
                  upState_q <= UP_IDLE;
               end else begin
                  upData_q  <= upShift_q[RESULT_W-1];
                  upShift_q <= {upShift_q[RESULT_W-2:0], 1'b0};
                  upBits_q  <= upBits_q + 5'h01;
               end
            end
         endcase
      end
   end

   assign link.bitClk = bitClk_q;
   assign link.upData = upData_q;
   assign link.upLoad = upLoad_q;

   // ************************************************************
   // downstream channel receiver
   // ************************************************************
   logic [1:0] rclkSync_q;
   logic [1:0] dataSync_q;
   logic [1:0] loadSync_q;
   logic       rclkPrev_q;
   logic       loadPrev_q;
   logic       rclkRise;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rclkSync_q <= '0;
         dataSync_q <= '0;
         loadSync_q <= '0;
         rclkPrev_q <= 1'b0;
         loadPrev_q <= 1'b0;
      end else begin
         rclkSync_q <= {rclkSync_q[0], link.retClk};
         dataSync_q <= {dataSync_q[0], link.downData};
         loadSync_q <= {loadSync_q[0], link.downLoad};
         rclkPrev_q <= rclkSync_q[1];
         loadPrev_q <= loadSync_q[1];
      end
   end
   assign rclkRise = rclkSync_q[1] && !rclkPrev_q;

   logic [CHREG_W-1:0] chShift_q;
   logic [3:0]         chBits_q;
   logic               inFrame_q;
   logic [CHAN_W-1:0]  muxAddr_q;

   // the load strobe opens a frame; bits are taken on returned rises
   // the rise under the strobe carries no bit, so it is skipped
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         chShift_q <= '0;
         chBits_q  <= '0;
         inFrame_q <= 1'b0;
         muxAddr_q <= '0;
      end else begin
         if (loadSync_q[1] && !loadPrev_q) begin
            inFrame_q <= 1'b1;
            chBits_q  <= '0;
         end else if (inFrame_q && rclkRise && !loadSync_q[1]
                      && chBits_q != 4'(CHREG_W)) begin
            chShift_q <= {chShift_q[CHREG_W-2:0], dataSync_q[1]};
            chBits_q  <= chBits_q + 4'h1;
         end else if (inFrame_q && chBits_q == 4'(CHREG_W)
                      && !loadSync_q[1]) begin
            // top two bits of the byte are dropped
            muxAddr_q <= chShift_q[CHAN_W-1:0];
            inFrame_q <= 1'b0;
         end
      end
   end

   assign muxLow  = muxAddr_q[TIER_W-1:0];
   assign muxHigh = muxAddr_q[CHAN_W-1:TIER_W];
endmodule

// ### design/amx_host.sv
// host end: returns bit clock, receives results, sends channels
// assumes it shares the core clock with the device end
module amx_host
   import amx_pkg::*;
(
   input  wire logic                 core_clk,
   input  wire logic                 resetn,
   amx_link_if.host                  link,
   input  wire amx_pkg::amx_chan_t   nextChan,
   output amx_pkg::amx_result_t      result,
   output logic                      resultValid
);
   import amx_pkg::*;

   assign link.retClk = link.bitClk;

   // ************************************************************
   // receive side, sampled on bit clock rising edges
   // ************************************************************
   logic        clkPrev_q;
   logic        clkRise;
   logic        clkFall;
   logic        frame_q;
   logic [4:0]  bits_q;
   amx_result_t shift_q;
   amx_result_t result_q;
   logic        valid_q;
   logic [CHREG_W-1:0] tx_q;
   logic        txData_q;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         clkPrev_q <= 1'b0;
      end else begin
         clkPrev_q <= link.bitClk;
      end
   end
   assign clkRise = link.bitClk && !clkPrev_q;
   assign clkFall = !link.bitClk && clkPrev_q;

   // sync opens the input frame and, tied, the output frame too
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         frame_q  <= 1'b0;
         bits_q   <= '0;
         shift_q  <= '0;
         result_q <= '0;
         valid_q  <= 1'b0;
         tx_q     <= '0;
         txData_q <= 1'b0;
      end else begin
         valid_q <= 1'b0;
         if (clkRise && link.upLoad) begin
            frame_q  <= 1'b1;
            bits_q   <= '0;
            tx_q     <= {2'b00, nextChan};
         end else if (clkRise && frame_q) begin
            shift_q  <= {shift_q[RESULT_W-2:0], link.upData};
            bits_q   <= bits_q + 5'h01;
            if (bits_q == 5'(RESULT_W-1)) begin
               frame_q  <= 1'b0;
               result_q <= {shift_q[RESULT_W-2:0], link.upData};
               valid_q  <= 1'b1;
            end
         end else if (clkFall && frame_q) begin
            // channel bits change on falls so they stand at each rise
            txData_q <= tx_q[CHREG_W-1];
            tx_q     <= {tx_q[CHREG_W-2:0], 1'b0};
         end
      end
   end

   assign link.downLoad = link.upLoad;
   assign link.downData = txData_q;
   assign result        = result_q;
   assign resultValid   = valid_q;
endmodule

// ### tb/amx_link_monitor.sv
// assertions on the serial link between device and host ends
// assumes one core clock and the link signals wired in as inputs
module amx_link_monitor (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic bitClk,
   input wire logic retClk,
   input wire logic upData,
   input wire logic upLoad,
   input wire logic downData,
   input wire logic downLoad
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int FRAME_CYC =
      int'(amx_pkg::MIN_TICKS * 2 * amx_pkg::BIT_HALF);
   logic [31:0] gap_q;
   logic        seen_q;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);

   // ************************************************************
   // frame spacing counter
   // ************************************************************
   // frames may be skipped while the fifo is empty, so only a whole
   // number of pulse periods between frames is demanded
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         gap_q  <= '0;
         seen_q <= 1'b0;
      end else if ($rose(upLoad)) begin
         gap_q  <= 32'h1;
         seen_q <= 1'b1;
      end else begin
         gap_q  <= gap_q + 32'h1;
      end
   end

   // ************************************************************
   // link properties
   // ************************************************************
   a_ret_clk_tied: assert property (retClk == bitClk)
      else $error("returned clock differs from bit clock");
   a_load_tie: assert property (downLoad == upLoad)
      else $error("output load differs from input load");
   a_bit_clk_high: assert property ($rose(bitClk) |->
      bitClk[*5] ##1 !bitClk)
      else $error("bit clock high phase not five cycles");
   a_bit_clk_low: assert property ($fell(bitClk) |->
      !bitClk[*5] ##1 bitClk)
      else $error("bit clock low phase not five cycles");
   a_load_one_bit: assert property ($rose(upLoad) |->
      upLoad[*8] ##1 upLoad[*2] ##1 !upLoad)
      else $error("load strobe not one bit period long");
   a_load_on_fall: assert property ($rose(upLoad) |-> !bitClk)
      else $error("load strobe rose while bit clock high");
   a_frame_spacing: assert property ($rose(upLoad) && seen_q |->
      (gap_q % FRAME_CYC) == 0)
      else $error("frames not spaced by whole pulse periods");
   a_up_data_fall: assert property ($changed(upData) |-> !bitClk)
      else $error("result bit changed while bit clock high");
   a_down_data_fall: assert property ($changed(downData) |-> !retClk)
      else $error("channel bit changed while returned clock high");

   c_frame: cover property ($rose(upLoad));
   c_load_end: cover property ($fell(downLoad));
   c_chan_bit: cover property ($changed(downData));
endmodule

// ### tb/adc_mux_serial_sequencer_test.sv
// self-checking bench: device and host ends joined by the link
// assumes the default divider start and a four word fifo
module adc_mux_serial_sequencer_test;
   timeunit 1ns;
   timeprecision 1ps;
   import amx_pkg::*;
   logic        coreClk = 1'b0;
   logic        resetn;
   amx_result_t convData;
   logic        convValid;
   logic        convReady;
   logic        convPulse;
   logic [2:0]  muxLow;
   logic [2:0]  muxHigh;
   amx_chan_t   nextChan;
   amx_result_t result;
   logic        resultValid;
   amx_result_t gotQ[$];
   int          numErrors;
   int          totalChecks;

   always #5 coreClk = ~coreClk;
   always @(negedge coreClk) if (resultValid) gotQ.push_back(result);

   amx_link_if i_amx_link_if ();
   amx_device #(.DIV_START(DIV_START_RST), .DEPTH(FIFO_DEPTH)) i_amx_device (
      .core_clk(coreClk), .resetn, .link(i_amx_link_if), .convData,
      .convValid, .convReady, .convPulse, .muxLow, .muxHigh);
   amx_host i_amx_host (.core_clk(coreClk), .resetn, .link(i_amx_link_if),
      .nextChan, .result, .resultValid);
   amx_link_monitor i_amx_link_monitor (.core_clk(coreClk), .resetn,
      .bitClk(i_amx_link_if.bitClk), .retClk(i_amx_link_if.retClk),
      .upData(i_amx_link_if.upData), .upLoad(i_amx_link_if.upLoad),
      .downData(i_amx_link_if.downData),
      .downLoad(i_amx_link_if.downLoad));

   // ************************************************************
   // shared tasks
   // ************************************************************
   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         numErrors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("checks %0d errors %0d", totalChecks, numErrors);
      if (numErrors == 0 && totalChecks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // counts falling edges until the conversion pulse is seen
   task automatic waitPulse(output int n);
      n = 0;
      do begin
         @(negedge coreClk);
         n++;
         if (n > 2000) begin
            numErrors++;
            summarize();
         end
      end while (convPulse !== 1'b1);
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   // fill the fifo until it refuses, then let frames drain it
   task automatic fillDrain();
      amx_result_t vals[5] = '{FULL_POS, FULL_NEG, 16'h0001, 16'hFFFF,
                               16'h1234};
      int n;
      convValid = 1'b1;
      foreach (vals[i]) begin
         convData = vals[i];
         check("convReady", 16'(convReady), 16'(i < 4));
         @(negedge coreClk);
      end
      convValid = 1'b0;
      n = 0;
      while (gotQ.size() < 4 && n < 6000) begin
         @(negedge coreClk);
         n++;
      end
      if (gotQ.size() < 4) begin
         numErrors++;
         summarize();
      end
      repeat (1500) @(negedge coreClk);
      check("result count", 16'(gotQ.size()), 16'd4);
      for (int i = 0; i < 4 && i < gotQ.size(); i++)
         check("result", gotQ[i], vals[i]);
      check("convReady drained", 16'(convReady), 16'h1);
   endtask

   // send channels, watch pulse spacing and the mux address update
   task automatic chanSweep();
      amx_chan_t chans[4] = '{6'h00, 6'h3F, 6'h2E, 6'h11};
      amx_chan_t prev;
      int n;
      int gapExp;
      prev = '0;
      gapExp = MIN_TICKS * 2 * BIT_HALF - 1;
      foreach (chans[i]) begin
         waitPulse(n);
         nextChan  = chans[i];
         convData  = 16'h0100 + 16'(i);
         convValid = 1'b1;
         @(negedge coreClk);
         convValid = 1'b0;
         check("pulse width", 16'(convPulse), 16'h0);
         check("mux held", 16'({muxHigh, muxLow}), 16'(prev));
         waitPulse(n);
         check("pulse gap", 16'(n), 16'(gapExp));
         check("sweep result", gotQ[$], 16'h0100 + 16'(i));
         repeat (300) @(negedge coreClk);
         check("muxLow", 16'(muxLow), 16'(chans[i][2:0]));
         check("muxHigh", 16'(muxHigh), 16'(chans[i][5:3]));
         prev = chans[i];
      end
   endtask

   initial begin
      resetn      = 1'b0;
      convData    = '0;
      convValid   = 1'b0;
      nextChan    = '0;
      numErrors   = 0;
      totalChecks = 0;
      repeat (6) @(negedge coreClk);
      resetn = 1'b1;
      fillDrain();
      chanSweep();
      summarize();
   end
endmodule
